/* File: src/ppmpc_pkg.sv */
// Package for the port pin mode and pull-up control block.
// Assumes an 8-bit register-addressing interface into register bank one.
`default_nettype none
package ppmpc_pkg;
	localparam logic [7:0] ADDR_PORT0_LOW_PIN_MODE  = 8'h_e1;
	localparam logic [7:0] ADDR_PORT0_PULLUP_ENABLE = 8'h_e2;
	localparam logic [7:0] ADDR_PORT1_LOW_PIN_MODE  = 8'h_e3;
	localparam logic [7:0] RESET_PORT0_LOW_PIN_MODE  = 8'h_00;
	localparam logic [7:0] RESET_PORT0_PULLUP_ENABLE = 8'h_00;
	localparam logic [7:0] RESET_PORT1_LOW_PIN_MODE  = 8'h_00;
	localparam logic [7:0] PORT1_USED_MASK = 8'h_0f;
	localparam int PORT0_LOW_PINS = 4;
	localparam int PORT1_PINS     = 2;
	// Pin mode field codes
	localparam logic [1:0] MODE_SCHMITT  = 2'h_0;
	localparam logic [1:0] MODE_CODE01   = 2'h_1;
	localparam logic [1:0] MODE_ANALOG   = 2'h_2;
	localparam logic [1:0] MODE_PUSHPULL = 2'h_3;
endpackage
`default_nettype wire

/* File: src/ppmpc_pin_decode.sv */
// One pin's mode field decoded into drive, analog, buzzer and pull-up controls.
// Assumes the field comes from a register on the same clock.
`default_nettype none
module ppmpc_pin_decode
(
	// Configuration
	input  wire logic [1:0] mode,
	input  wire logic       pullup_bit,
	input  wire logic       code01_is_buzzer,
	input  wire logic       code01_is_pullup,
	// Decoded controls
	output logic            drive_en,
	output logic            analog_sel,
	output logic            buzzer_sel,
	output logic            pullup_on
);
	import ppmpc_pkg::*;

	always_comb
	begin
		drive_en   = (mode == MODE_PUSHPULL);
		analog_sel = (mode == MODE_ANALOG);
		buzzer_sel = (mode == MODE_CODE01) && code01_is_buzzer;
		// Pull-up only in plain input modes; off when driven or alternate
		pullup_on  = ((mode == MODE_SCHMITT) && pullup_bit)
		           || ((mode == MODE_CODE01) && code01_is_pullup);
	end
endmodule
`default_nettype wire

/* File: src/ppmpc_top.sv */
// Mode and pull-up control for port 0 pins 3..0 and port 1 pins 1..0.
// Assumes a single-cycle register-addressing strobe from the CPU core, bank one.
//
// Notes on behaviour
// - port0 low mode byte: four 2-bit fields; 00 in, 10 analog, 11 out, 01 buzzer (pin 0 only).
// - port0 pull-up register: bit n enables pull-up of pin n.
// - port0 pull-up forced off in output or alternate modes; input mode obeys bit.
// - port1 low mode byte: bits 7-4 unused; 00 in, 01 in+pull-up, 10 analog, 11 out.
// - registers sit at consecutive bank one addresses, register addressing only.
`default_nettype none
module ppmpc_top
(
	// Clock and reset
	input  wire logic                               clock,
	input  wire logic                               nrst,
	// Register access from the core
	input  wire logic                               reg_bank_one,
	input  wire logic                               reg_addr_mode,
	input  wire logic [7:0]                         reg_addr,
	input  wire logic                               reg_write,
	input  wire logic [7:0]                         reg_wdata,
	output logic      [7:0]                         reg_rdata,
	// Port 0 controls
	output logic      [ppmpc_pkg::PORT0_LOW_PINS-1:0] port0_drive_en,
	output logic      [ppmpc_pkg::PORT0_LOW_PINS-1:0] port0_analog_sel,
	output logic                                    buzzer_output_sel,
	output logic      [7:0]                         port0_pullup_on,
	// Port 1 controls
	output logic      [ppmpc_pkg::PORT1_PINS-1:0]   port1_drive_en,
	output logic      [ppmpc_pkg::PORT1_PINS-1:0]   port1_analog_sel,
	output logic      [ppmpc_pkg::PORT1_PINS-1:0]   port1_pullup_on
);
	import ppmpc_pkg::*;

	// Field of one pin inside a mode byte
	function automatic logic [1:0] pin_field(input logic [7:0] mode_byte, input int pin);
		pin_field = mode_byte[2*pin+:2];
	endfunction

	// Address decode for the write paths; the read mux decodes with its own case
	function automatic logic addr_is(input logic [7:0] addr, input logic [7:0] target);
		addr_is = (addr == target);
	endfunction

	// Stored configuration
	logic [7:0] port0_low_pin_mode;
	logic [7:0] port0_pullup_enable;
	logic [7:0] port1_low_pin_mode;

	// Bus decode
	logic       reg_hit;
	logic       reg_wr_hit;
	logic [7:0] next_rdata;

	// Per-pin decode results
	logic [7:0]                next_p0_pull_byte;
	logic [PORT0_LOW_PINS-1:0] next_p0_drive;
	logic [PORT0_LOW_PINS-1:0] next_p0_analog;
	logic [PORT0_LOW_PINS-1:0] next_p0_pull;
	logic [PORT0_LOW_PINS-1:0] next_p0_buzz;
	logic [PORT1_PINS-1:0]     next_p1_drive;
	logic [PORT1_PINS-1:0]     next_p1_analog;
	logic [PORT1_PINS-1:0]     next_p1_pull;
	logic [PORT1_PINS-1:0]     next_p1_buzz;

	// Other addressing modes cannot reach these locations
	assign reg_hit = reg_bank_one && reg_addr_mode;
	assign reg_wr_hit = reg_hit && reg_write;

	// One process per register keeps each write decode on its own
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			port0_low_pin_mode <= RESET_PORT0_LOW_PIN_MODE;
		else if (reg_wr_hit && addr_is(reg_addr, ADDR_PORT0_LOW_PIN_MODE))
			port0_low_pin_mode <= reg_wdata;
	end

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			port0_pullup_enable <= RESET_PORT0_PULLUP_ENABLE;
		else if (reg_wr_hit && addr_is(reg_addr, ADDR_PORT0_PULLUP_ENABLE))
			port0_pullup_enable <= reg_wdata;
	end

	// Unused upper nibble is not stored, so it reads back zero
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			port1_low_pin_mode <= RESET_PORT1_LOW_PIN_MODE;
		else if (reg_wr_hit && addr_is(reg_addr, ADDR_PORT1_LOW_PIN_MODE))
			port1_low_pin_mode <= reg_wdata & PORT1_USED_MASK;
	end

	// Read mux; unmapped or wrong mode reads zero
	always_comb
	begin
		next_rdata = 8'h_00;
		if (reg_hit)
		begin
			case (reg_addr)
				ADDR_PORT0_LOW_PIN_MODE:  next_rdata = port0_low_pin_mode;
				ADDR_PORT0_PULLUP_ENABLE: next_rdata = port0_pullup_enable;
				ADDR_PORT1_LOW_PIN_MODE:  next_rdata = port1_low_pin_mode;
				default:                  next_rdata = 8'h_00;
			endcase
		end
	end

	// Registered read data, one cycle after the address
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			reg_rdata <= 8'h_00;
		else
			reg_rdata <= next_rdata;
	end

	genvar i;
	generate
		for (i = 0; i < PORT0_LOW_PINS; i++)
		begin : g_p0
			// Code 01 means buzzer only on pin 0; elsewhere it is unused
			ppmpc_pin_decode u_dec
			(
				.mode             (pin_field(port0_low_pin_mode, i)),
				.pullup_bit       (port0_pullup_enable[i]),
				.code01_is_buzzer (i == 0),
				.code01_is_pullup (1'b0),
				.drive_en         (next_p0_drive[i]),
				.analog_sel       (next_p0_analog[i]),
				.buzzer_sel       (next_p0_buzz[i]),
				.pullup_on        (next_p0_pull[i])
			);
		end
		for (i = 0; i < PORT1_PINS; i++)
		begin : g_p1
			ppmpc_pin_decode u_dec
			(
				.mode             (pin_field(port1_low_pin_mode, i)),
				.pullup_bit       (1'b0),
				.code01_is_buzzer (1'b0),
				.code01_is_pullup (1'b1),
				.drive_en         (next_p1_drive[i]),
				.analog_sel       (next_p1_analog[i]),
				.buzzer_sel       (next_p1_buzz[i]),
				.pullup_on        (next_p1_pull[i])
			);
		end
	endgenerate

	// Upper pins' modes live elsewhere; their enable bits pass straight through
	always_comb
	begin
		next_p0_pull_byte = {port0_pullup_enable[7:4], next_p0_pull};
	end

	// Outputs registered: one cycle after the register write
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			port0_drive_en <= '0;
		else
			port0_drive_en <= next_p0_drive;
	end

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			port0_analog_sel <= '0;
		else
			port0_analog_sel <= next_p0_analog;
	end

	// Only pin 0 can carry the buzzer
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			buzzer_output_sel <= 1'b0;
		else
			buzzer_output_sel <= next_p0_buzz[0];
	end

	// Registered so a mode change and its pull-up change land together
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			port0_pullup_on <= 8'h_00;
		else
			port0_pullup_on <= next_p0_pull_byte;
	end

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			port1_drive_en <= '0;
		else
			port1_drive_en <= next_p1_drive;
	end

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			port1_analog_sel <= '0;
		else
			port1_analog_sel <= next_p1_analog;
	end

	// Port 1 has no enable register; code 01 alone turns the pull-up on
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			port1_pullup_on <= '0;
		else
			port1_pullup_on <= next_p1_pull;
	end

	logic unused_buzz;
	assign unused_buzz = ^{next_p0_buzz[PORT0_LOW_PINS-1:1], next_p1_buzz};
endmodule
`default_nettype wire

/* File: test/ppmpc_props.sv */
// Checker on ppmpc_top ports.
// Assumes one clock domain; bound below.
`default_nettype none
module ppmpc_props import ppmpc_pkg::*;
(
	// Clock, reset, register access
	input wire logic	clock,
	input wire logic	nrst,
	input wire logic	reg_bank_one,
	input wire logic	reg_addr_mode,
	input wire logic [7:0]	reg_addr,
	input wire logic	reg_write,
	input wire logic [7:0]	reg_wdata,
	input wire logic [7:0]	reg_rdata,
	// Pin controls
	input wire logic [3:0]	port0_drive_en,
	input wire logic [3:0]	port0_analog_sel,
	input wire logic	buzzer_output_sel,
	input wire logic [7:0]	port0_pullup_on,
	input wire logic [1:0]	port1_drive_en,
	input wire logic [1:0]	port1_pullup_on
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	wire	hit = reg_bank_one & reg_addr_mode & reg_write;
	function automatic logic [3:0] f4(logic [7:0] d, logic [1:0] c);
		for (int i = 0; i < 4; i++)
			f4[i] = d[2*i+:2] == c;
	endfunction
	AST_P0: assert property (hit && reg_addr == ADDR_PORT0_LOW_PIN_MODE |-> ##2
		{port0_drive_en, port0_analog_sel} ==
		{f4($past(reg_wdata, 2), 2'h_3), f4($past(reg_wdata, 2), 2'h_2)}) else $error("mode wrong");
	AST_BUZ: assert property (hit && reg_addr == ADDR_PORT0_LOW_PIN_MODE |-> ##2
		buzzer_output_sel == ($past(reg_wdata[1:0], 2) == 2'h_1)) else $error("buzzer wrong");
	AST_PU_HI: assert property (hit && reg_addr == ADDR_PORT0_PULLUP_ENABLE |-> ##2
		port0_pullup_on[7:4] == $past(reg_wdata[7:4], 2)) else $error("pull-up wrong");
	AST_PU_OFF: assert property ((port0_pullup_on[3:0] & (port0_drive_en
		| port0_analog_sel | {3'h_0, buzzer_output_sel})) == 4'h_0) else $error("pull-up kept");
	AST_P1: assert property (hit && reg_addr == ADDR_PORT1_LOW_PIN_MODE |=> ##1
		{2'h_0, port1_drive_en, 2'h_0, port1_pullup_on} == {f4($past(reg_wdata, 2) & 8'h_0f,
		2'h_3), f4($past(reg_wdata, 2) & 8'h_0f, 2'h_1)}) else $error("port 1 wrong");
	AST_RD_OFF: assert property (!(reg_bank_one && reg_addr_mode) |=> reg_rdata == 8'h_00)
		else $error("stray read data");
	AST_RST: assert property ($rose(nrst) |-> {reg_rdata, port0_drive_en, port0_pullup_on} == '0)
		else $error("not cleared");
	cover property (buzzer_output_sel);
	cover property (|port1_pullup_on);
	cover property (|port0_pullup_on[3:0]);
endmodule
bind ppmpc_top ppmpc_props u_props (.*);
`default_nettype wire

/* File: test/ppmpc_top_tb.sv */
// Self-checking bench for ppmpc_top.
// Assumes the checker binds itself.
`default_nettype none
module ppmpc_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic	clock = 0, nrst = 0, reg_bank_one = 0, reg_addr_mode = 0, reg_write = 0;
	logic	probe = 0, pend = 0, buzzer_output_sel;
	logic [7:0]	reg_addr = 0, reg_wdata = 0, reg_rdata, port0_pullup_on, k;
	logic [7:0]	m [3] = '{default: 8'h_00};
	logic [3:0]	port0_drive_en, port0_analog_sel;
	logic [1:0]	port1_drive_en, port1_analog_sel, port1_pullup_on;
	logic [15:0]	tbl [5] = '{16'h_e1e4, 16'h_e11b, 16'h_e139, 16'h_e3f6, 16'h_e30d};
	logic [30:0]	q [$];
	logic [31:0]	seed = 32'h_0000_8422;
	int	fail_count = 0, compares = 0;
	wire [30:0]	obs = {reg_rdata, port0_drive_en, port0_analog_sel, buzzer_output_sel,
		port0_pullup_on, port1_drive_en, port1_analog_sel, port1_pullup_on};
	ppmpc_top u_dut (.*);
	always #50 clock = ~clock;
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [22:0] pins();
		logic [3:0] d, n, z, e, a, u;
		for (int i = 0; i < 4; i++)
		begin
			{d[i], n[i], z[i]} = {m[0][2*i+:2] == 2'h_3, m[0][2*i+:2] == 2'h_2, m[0][2*i+:2] == 2'h_0};
			{e[i], a[i], u[i]} = {m[2][2*i+:2] == 2'h_3, m[2][2*i+:2] == 2'h_2, m[2][2*i+:2] == 2'h_1};
		end
		return {d, n, m[0][1:0] == 2'h_1, m[1][7:4], m[1][3:0] & z, e[1:0], a[1:0], u[1:0]};
	endfunction
	task automatic check(logic [30:0] seen, logic [30:0] exp);
		compares++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic finish_test();
		if (fail_count == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Reads queue their expectation; writes update the model
	task automatic acc(logic [7:0] a, logic [7:0] d, logic w, logic [1:0] h);
		@(negedge clock);
		{reg_addr, reg_wdata, reg_write, probe, reg_bank_one, reg_addr_mode} = {a, d, w, !w, h};
		k = a - 8'h_e1;
		if (h == 2'h_3 && k < 3 && w)
			m[k] = d & (k == 2 ? 8'h_0f : 8'h_ff);
		if (!w)
			q.push_back({h == 2'h_3 && k < 3 ? m[k] : 8'h_00, pins()});
	endtask
	task automatic sweep();
		for (int i = 0; i < 5; i++)
			acc(8'h_e0 + i[7:0], 8'h_00, 0, 2'h_3);
		acc(8'h_00, 8'h_00, 1, 2'h_0);
	endtask
	// Compare on the falling edge, once the launching edge has settled
	always @(negedge clock)
		if (pend)
			check(obs, q.pop_front());
	always @(posedge clock)
		pend <= probe;
	initial
	begin
		repeat (3) @(negedge clock);
		nrst = 1;
		sweep();
		acc(8'h_e2, 8'h_ff, 1, 2'h_3);
		foreach (tbl[j])
		begin
			acc(tbl[j][15:8], tbl[j][7:0], 1, 2'h_3);
			acc(tbl[j][15:8], 8'h_00, 0, 2'h_3);
		end
		// Random mix, incl. refused bank/mode and unmapped address
		for (int i = 0; i < 300; i++)
		begin
			seed = rnd();
			k = seed[7:0];
			acc(8'h_e1 + {6'h_00, seed[9:8]}, k, seed[10], seed[12:11] | {2{seed[13]}});
		end
		acc(8'h_00, 8'h_00, 1, 2'h_0);
		@(negedge clock);
		nrst = 0;
		m = '{default: 8'h_00};
		@(negedge clock);
		nrst = 1;
		sweep();
		repeat (2) @(negedge clock);
		finish_test();
	end
	initial
	begin
		repeat (5000) @(posedge clock);
		fail_count++;
		finish_test();
	end
endmodule
`default_nettype wire
